// ### src/synth_pkg.sv
package synth_pkg;

	// ****************************************
	// Bus and register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_REF = 8'h04;
	localparam logic [7:0] OFF_AUX = 8'h08;
	localparam logic [7:0] OFF_MAIN_A = 8'h0C;
	localparam logic [7:0] OFF_MAIN_B = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_WORK = 8'h18;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [31:0] MASK_CTRL = 32'h00000001;
	localparam logic [31:0] MASK_REF = 32'h0003FFFF;
	localparam logic [31:0] MASK_AUX = 32'h00003FFF;
	localparam logic [31:0] MASK_MAIN_A = 32'h03FFFFFF;
	localparam logic [31:0] MASK_MAIN_B = 32'h00003FFF;

	localparam logic [31:0] RST_CTRL = 32'h00000000;
	localparam logic [31:0] RST_REF = 32'h00000004;
	localparam logic [31:0] RST_AUX = 32'h00000070;
	localparam logic [31:0] RST_MAIN_A = 32'h00000000;
	localparam logic [31:0] RST_MAIN_B = 32'h00000000;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_STROBE = 0;
	localparam int REF_NR_LSB = 0;
	localparam int REF_NR_W = 12;
	localparam int REF_RSM_LSB = 12;
	localparam int REF_RSA_LSB = 14;
	localparam int REF_EM = 16;
	localparam int REF_EA = 17;
	localparam int AUX_SCHEME = 0;
	localparam int AUX_SW_LSB = 1;
	localparam int AUX_SW_W = 3;
	localparam int AUX_CO_LSB = 4;
	localparam int AUX_CO_W = 10;
	localparam int A_BASE_LSB = 0;
	localparam int A_BASE_W = 12;
	localparam int A_M65_LSB = 12;
	localparam int A_M65_W = 6;
	localparam int A_M65_TRI_W = 4;
	localparam int A_M72_LSB = 18;
	localparam int A_M72_W = 4;
	localparam int A_SW_LSB = 0;
	localparam int A_SW_W = 5;
	localparam int A_PG_LSB = 5;
	localparam int A_PG_W = 13;
	localparam int A_NF_LSB = 22;
	localparam int B_CN_LSB = 0;
	localparam int B_PR_LSB = 8;
	localparam int B_FRAC_MODULUS_LSB = 10;
	localparam int ST_PENDING = 0;
	localparam int ST_OVF = 1;
	localparam int ST_ALT = 2;
	localparam int ST_ACC_LSB = 4;
	localparam int ST_REFEN = 8;
	localparam int WK_N_LSB = 0;
	localparam int WK_PR_LSB = 20;
	localparam int WK_NF_LSB = 24;

	// ****************************************
	// Divider constants
	// ****************************************
	localparam logic [11:0] NR_MIN = 12'h004;
	localparam int MAIN_PSC_LOW = 32;
	localparam int AUX_PSC_LOW = 8;
	localparam int MAIN_SW_W = 5;
	localparam int MAIN_CNT_W = 14;
	localparam logic [18:0] STD_MOD_A = 19'h00040;
	localparam logic [18:0] STD_MOD_B = 19'h00041;
	localparam logic [18:0] STD_MOD_C = 19'h00048;
	localparam logic [18:0] STD_BASE_OFS = 19'h00002;

endpackage

// ### src/dual_modulus_divider.sv
module dual_modulus_divider #(
	parameter int LOW_MOD = 8,
	parameter int SW_W = 3,
	parameter int CNT_W = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic in_edge,
	input wire logic stretch_in,
	input wire logic [SW_W-1:0] swallow_load,
	input wire logic [CNT_W-1:0] count_load,
	output logic terminal
);
	typedef struct packed {
		logic [7:0] psc;
		logic [SW_W-1:0] a;
		logic [CNT_W-1:0] b;
		logic stretch;
		logic reload;
		logic terminal;
	} div_state_t;

	div_state_t st;
	div_state_t next_st;
	logic [7:0] mod_top;

	// ****************************************
	// Prescaler and counters
	// ****************************************
	// The prescaler runs at the high modulus while swallow counts remain.
	// Load values are sampled one clock after terminal count, so the owner
	// may present the values it is writing in that same clock.
	always_comb
	begin
		next_st = st;
		next_st.terminal = 1'b0;
		mod_top = (st.a != '0) ? 8'(LOW_MOD) : 8'(LOW_MOD - 1);
		if (!enable)
		begin
			next_st.psc = 8'h00;
			next_st.a = swallow_load;
			next_st.b = count_load;
			next_st.stretch = 1'b0;
			next_st.reload = 1'b0;
		end
		else if (st.reload)
		begin
			next_st.reload = 1'b0;
			next_st.psc = 8'h00;
			next_st.a = swallow_load;
			next_st.b = count_load;
			next_st.stretch = stretch_in;
		end
		else if (in_edge)
		begin
			if (st.stretch)
				next_st.stretch = 1'b0;
			else if (st.psc != mod_top)
				next_st.psc = st.psc + 8'h01;
			else
			begin
				next_st.psc = 8'h00;
				if (st.a != '0)
					next_st.a = st.a - 1'b1;
				if (st.b <= CNT_W'(1))
				begin
					next_st.terminal = 1'b1;
					next_st.reload = 1'b1;
				end
				else
					next_st.b = st.b - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign terminal = st.terminal;
endmodule

// ### src/frac_n_synth_dividers.sv
// Notes on behaviour
// - Reference buffer on when either enable set.
// - Reference divided by twelve-bit ratio, four up.
// - Separate main and aux postscale by 1,2,4,8.
// - Aux stage and divider run only when enabled.
// - Aux divider is 8/9 prescaler with swallow.
// - Main divider runs only when main enabled.
// - Scheme bit picks standard or alternate main scheme.
// - Standard ratio 64(base+2)+65m65 plus 72 term.
// - Alternate uses 5-bit swallow, 13-bit program count.
// - Divide 33 until swallow done, then 32.
// - New main word loads at terminal count, or at once while main is off.
// - Accumulator adds numerator modulo modulus; overflow adds one.
// - Modulus 1 to 16, numerator below it.
// - Zero numerator keeps accumulator zero, divide by N.
// - Accumulator exported every main divider cycle.
// - Scale and modulus select move with main word.
// - Scheme bit is bit zero of aux word.
module frac_n_synth_dividers (
	input wire logic clk,
	input wire logic rst,
	input wire logic [synth_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [synth_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic ref_osc_input,
	input wire logic aux_vco_input,
	input wire logic main_rf_input,
	output logic ref_buffer_enable,
	output logic aux_stage_enable,
	output logic main_stage_enable,
	output logic main_ref_pulse,
	output logic aux_ref_pulse,
	output logic main_div_pulse,
	output logic aux_div_pulse,
	output logic [3:0] frac_acc_out,
	output logic [7:0] comp_current_scale
);
	import synth_pkg::*;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] ref_w;
		logic [31:0] aux_w;
		logic [31:0] a_tmp;
		logic [31:0] b_tmp;
		logic [4:0] work_a;
		logic [13:0] work_b;
		logic work_alt;
		logic [3:0] work_nf;
		logic [3:0] work_fmod1;
		logic [7:0] work_cn;
		logic [1:0] work_pr;
		logic pending;
		logic [3:0] acc;
		logic ovf;
		logic ref_s1;
		logic ref_s2;
		logic ref_s3;
		logic aux_s1;
		logic aux_s2;
		logic aux_s3;
		logic rf_s1;
		logic rf_s2;
		logic rf_s3;
		logic [11:0] ref_cnt;
		logic [2:0] post_cnt;
		logic main_ref_pulse;
		logic aux_ref_pulse;
		logic ref_en;
		logic aux_en;
		logic main_en;
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;

	localparam state_t ST_RESET = '{
		ctrl: RST_CTRL,
		ref_w: RST_REF,
		aux_w: RST_AUX,
		a_tmp: RST_MAIN_A,
		b_tmp: RST_MAIN_B,
		default: '0
	};

	state_t st;
	state_t next_st;
	logic main_term;
	logic aux_term;

	// ****************************************
	// Helper functions
	// ****************************************
	function automatic logic [2:0] post_mask(input logic [1:0] sel);
		post_mask = 3'(({2'b00, 1'b1} << sel) - 3'h1);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		merge = r & mask;
	endfunction

	function automatic logic [18:0] std_ratio(input logic [31:0] aw, input logic [1:0] pr);
		logic [18:0] base;
		logic [18:0] m65;
		logic [18:0] m72;
		logic [18:0] n;
		base = 19'(aw[A_BASE_LSB +: A_BASE_W]);
		m65 = pr[1] ? 19'(aw[A_M65_LSB +: A_M65_TRI_W]) : 19'(aw[A_M65_LSB +: A_M65_W]);
		m72 = 19'(aw[A_M72_LSB +: A_M72_W]);
		n = (base + STD_BASE_OFS) * STD_MOD_A + m65 * STD_MOD_B;
		if (pr[1])
			n = n + (m72 + 19'h00001) * STD_MOD_C;
		std_ratio = n;
	endfunction

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb
	begin
		logic do_write;
		logic a_write;
		logic transfer;
		logic ref_edge;
		logic [11:0] nr;
		logic [11:0] nr_last;
		logic [18:0] n_std;
		logic [4:0] frac_modulus;
		logic [4:0] nf_eff;
		logic [4:0] sum;
		logic [31:0] rd;
		do_write = 1'b0;
		a_write = 1'b0;
		transfer = 1'b0;
		ref_edge = 1'b0;
		nr = 12'h000;
		nr_last = 12'h000;
		n_std = 19'h00000;
		frac_modulus = 5'h00;
		nf_eff = 5'h00;
		sum = 5'h00;
		rd = 32'h00000000;
		next_st = st;

		// Two-stage synchronisers and edge history for the three pins.
		next_st.ref_s1 = ref_osc_input;
		next_st.ref_s2 = st.ref_s1;
		next_st.ref_s3 = st.ref_s2;
		next_st.aux_s1 = aux_vco_input;
		next_st.aux_s2 = st.aux_s1;
		next_st.aux_s3 = st.aux_s2;
		next_st.rf_s1 = main_rf_input;
		next_st.rf_s2 = st.rf_s1;
		next_st.rf_s3 = st.rf_s2;

		next_st.ref_en = st.ref_w[REF_EM] | st.ref_w[REF_EA];
		next_st.aux_en = st.ref_w[REF_EA];
		next_st.main_en = st.ref_w[REF_EM];

		// ****************************************
		// Reference divider and postscalers
		// ****************************************
		next_st.main_ref_pulse = 1'b0;
		next_st.aux_ref_pulse = 1'b0;
		ref_edge = st.ref_s2 & ~st.ref_s3 & st.ref_en;
		nr = st.ref_w[REF_NR_LSB +: REF_NR_W];
		nr_last = ((nr < NR_MIN) ? NR_MIN : nr) - 12'h001;
		if (!st.ref_en)
		begin
			next_st.ref_cnt = 12'h000;
			next_st.post_cnt = 3'h0;
		end
		else if (ref_edge)
		begin
			if (st.ref_cnt >= nr_last)
			begin
				next_st.ref_cnt = 12'h000;
				next_st.post_cnt = st.post_cnt + 3'h1;
				next_st.main_ref_pulse = (st.post_cnt & post_mask(st.ref_w[REF_RSM_LSB +: 2]))
					== post_mask(st.ref_w[REF_RSM_LSB +: 2]);
				next_st.aux_ref_pulse = (st.post_cnt & post_mask(st.ref_w[REF_RSA_LSB +: 2]))
					== post_mask(st.ref_w[REF_RSA_LSB +: 2]);
			end
			else
				next_st.ref_cnt = st.ref_cnt + 12'h001;
		end

		// ****************************************
		// Register bus slave
		// ****************************************
		if (st.bvalid & bready)
			next_st.bvalid = 1'b0;
		if (awvalid & st.awready)
		begin
			next_st.aw_full = 1'b1;
			next_st.aw_addr = {awaddr[7:2], 2'b00};
		end
		if (wvalid & st.wready)
		begin
			next_st.w_full = 1'b1;
			next_st.w_data = wdata;
			next_st.w_strb = wstrb;
		end
		do_write = st.aw_full & st.w_full & ~st.bvalid;
		if (do_write)
		begin
			next_st.aw_full = 1'b0;
			next_st.w_full = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			case (st.aw_addr)
				OFF_CTRL: next_st.ctrl = merge(st.ctrl, st.w_data, st.w_strb, MASK_CTRL);
				OFF_REF: next_st.ref_w = merge(st.ref_w, st.w_data, st.w_strb, MASK_REF);
				OFF_AUX: next_st.aux_w = merge(st.aux_w, st.w_data, st.w_strb, MASK_AUX);
				OFF_MAIN_A:
				begin
					next_st.a_tmp = merge(st.a_tmp, st.w_data, st.w_strb, MASK_MAIN_A);
					a_write = 1'b1;
				end
				OFF_MAIN_B: next_st.b_tmp = merge(st.b_tmp, st.w_data, st.w_strb, MASK_MAIN_B);
				OFF_STATUS, OFF_WORK: next_st.bresp = RESP_OKAY;
				default: next_st.bresp = RESP_SLVERR;
			endcase
		end

		if (st.rvalid & rready)
			next_st.rvalid = 1'b0;
		if (arvalid & st.arready)
		begin
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			case ({araddr[7:2], 2'b00})
				OFF_CTRL: rd = st.ctrl;
				OFF_REF: rd = st.ref_w;
				OFF_AUX: rd = st.aux_w;
				OFF_MAIN_A: rd = st.a_tmp;
				OFF_MAIN_B: rd = st.b_tmp;
				OFF_STATUS:
				begin
					rd[ST_PENDING] = st.pending;
					rd[ST_OVF] = st.ovf;
					rd[ST_ALT] = st.work_alt;
					rd[ST_ACC_LSB +: 4] = st.acc;
					rd[ST_REFEN] = st.ref_en;
				end
				OFF_WORK:
				begin
					rd[WK_N_LSB +: 19] = {st.work_b, st.work_a};
					rd[WK_PR_LSB +: 2] = st.work_pr;
					rd[WK_NF_LSB +: 4] = st.work_nf;
				end
				default: next_st.rresp = RESP_SLVERR;
			endcase
			next_st.rdata = rd;
		end

		// ****************************************
		// Synchronised reload of the main divider
		// ****************************************
		// A new main word waits for terminal count so the divider never
		// restarts mid-cycle; while the divider is off it loads at once.
		transfer = st.pending & st.ctrl[CTRL_STROBE] & (main_term | ~st.main_en);
		next_st.pending = (st.pending & ~transfer) | a_write;
		if (transfer)
		begin
			next_st.work_alt = st.aux_w[AUX_SCHEME];
			next_st.work_cn = st.b_tmp[B_CN_LSB +: 8];
			next_st.work_pr = st.b_tmp[B_PR_LSB +: 2];
			next_st.work_fmod1 = st.b_tmp[B_FRAC_MODULUS_LSB +: 4];
			next_st.work_nf = st.a_tmp[A_NF_LSB +: 4];
			if (st.aux_w[AUX_SCHEME])
			begin
				next_st.work_a = st.a_tmp[A_SW_LSB +: A_SW_W];
				next_st.work_b = {1'b0, st.a_tmp[A_PG_LSB +: A_PG_W]};
			end
			else
			begin
				n_std = std_ratio(st.a_tmp, st.b_tmp[B_PR_LSB +: 2]);
				next_st.work_a = n_std[4:0];
				next_st.work_b = n_std[18:5];
			end
			next_st.acc = 4'h0;
			next_st.ovf = 1'b0;
		end
		else if (main_term)
		begin
			frac_modulus = {1'b0, st.work_fmod1} + 5'h01;
			nf_eff = ({1'b0, st.work_nf} >= frac_modulus) ? frac_modulus - 5'h01 : {1'b0, st.work_nf};
			sum = {1'b0, st.acc} + nf_eff;
			if (sum >= frac_modulus)
			begin
				next_st.acc = 4'(sum - frac_modulus);
				next_st.ovf = 1'b1;
			end
			else
			begin
				next_st.acc = sum[3:0];
				next_st.ovf = 1'b0;
			end
		end
		if (!st.main_en)
		begin
			next_st.acc = 4'h0;
			next_st.ovf = 1'b0;
		end

		next_st.awready = ~next_st.aw_full & ~next_st.bvalid;
		next_st.wready = ~next_st.w_full & ~next_st.bvalid;
		next_st.arready = ~next_st.rvalid;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st <= ST_RESET;
		else
			st <= next_st;
	end

	// ****************************************
	// Dividers
	// ****************************************
	// The extra input edge of an overflow cycle comes from the
	// overflow flag being written in the reload clock.
	dual_modulus_divider #(
		.LOW_MOD(MAIN_PSC_LOW),
		.SW_W(MAIN_SW_W),
		.CNT_W(MAIN_CNT_W)
	) main_div (
		.clk(clk),
		.rst(rst),
		.enable(st.main_en),
		.in_edge(st.rf_s2 & ~st.rf_s3),
		.stretch_in(next_st.ovf),
		.swallow_load(next_st.work_a),
		.count_load(next_st.work_b),
		.terminal(main_term)
	);

	dual_modulus_divider #(
		.LOW_MOD(AUX_PSC_LOW),
		.SW_W(AUX_SW_W),
		.CNT_W(AUX_CO_W)
	) aux_div (
		.clk(clk),
		.rst(rst),
		.enable(st.aux_en),
		.in_edge(st.aux_s2 & ~st.aux_s3),
		.stretch_in(1'b0),
		.swallow_load(st.aux_w[AUX_SW_LSB +: AUX_SW_W]),
		.count_load(st.aux_w[AUX_CO_LSB +: AUX_CO_W]),
		.terminal(aux_term)
	);

	// ****************************************
	// Outputs
	// ****************************************
	assign awready = st.awready;
	assign wready = st.wready;
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign arready = st.arready;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;
	assign ref_buffer_enable = st.ref_en;
	assign aux_stage_enable = st.aux_en;
	assign main_stage_enable = st.main_en;
	assign main_ref_pulse = st.main_ref_pulse;
	assign aux_ref_pulse = st.aux_ref_pulse;
	assign main_div_pulse = main_term;
	assign aux_div_pulse = aux_term;
	assign frac_acc_out = st.acc;
	assign comp_current_scale = st.work_cn;
endmodule

// ### testbench/frac_n_synth_dividers_assertions.sv
module frac_n_synth_dividers_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire logic ref_buffer_enable,
	input wire logic aux_stage_enable,
	input wire logic main_stage_enable,
	input wire logic main_ref_pulse,
	input wire logic aux_ref_pulse,
	input wire logic main_div_pulse,
	input wire logic aux_div_pulse,
	input wire logic [3:0] frac_acc_out,
	input wire logic [7:0] comp_current_scale
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	ref_buf_or_a: assert property (ref_buffer_enable == (main_stage_enable || aux_stage_enable))
		else $error("reference buffer enable is not the or of both enables");
	aux_gated_a: assert property (aux_div_pulse |-> $past(aux_stage_enable, 2))
		else $error("aux divider pulse while aux stage off");
	main_gated_a: assert property (main_div_pulse |-> $past(main_stage_enable, 2))
		else $error("main divider pulse while main stage off");
	ref_gap_a: assert property (main_ref_pulse |=> !main_ref_pulse [*8])
		else $error("main reference pulses too close");
	aux_ref_gap_a: assert property ($rose(aux_ref_pulse) |=> !aux_ref_pulse [*8])
		else $error("aux reference pulses too close");
	main_div_gap_a: assert property (main_div_pulse |=> !main_div_pulse [*8])
		else $error("main divider pulses too close");
	aux_div_gap_a: assert property (aux_div_pulse |=> !aux_div_pulse [*8])
		else $error("aux divider pulses too close");
	acc_update_a: assert property ($changed(frac_acc_out) |-> $past(main_div_pulse) || frac_acc_out == 4'h0)
		else $error("accumulator moved outside a main divider cycle end");
	comp_sync_a: assert property ($changed(comp_current_scale) |-> $past(main_div_pulse) || !$past(main_stage_enable))
		else $error("compensation scale loaded off the synchronization point");
endmodule

// ### testbench/signal_source.sv
module signal_source #(
	parameter int HALF = 2
) (
	input wire logic clk,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	logic level = 1'h0;

	// Free-running oscillator: the pin toggles every HALF clock cycles.
	assign pin = level;
	always @(posedge clk)
	begin
		n <= (n == HALF - 1) ? 0 : n + 1;
		if (n == HALF - 1)
			level <= !level;
	end
endmodule

// ### testbench/tb_frac_n_synth_dividers.sv
module tb_frac_n_synth_dividers;
	timeunit 1ns;
	timeprecision 1ps;
	import synth_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, ref_in, aux_in, rf_in;
	logic ref_buffer_enable, aux_stage_enable, main_stage_enable;
	logic main_ref_pulse, aux_ref_pulse, main_div_pulse, aux_div_pulse;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rv;
	logic [3:0] frac_acc_out;
	logic [7:0] comp_current_scale;
	logic [3:0] pulse_vec;
	int bad_count = 0, n_tests = 0, sel = 0, skip = 0, acc_due = 0, cyc = 0, last = 0;
	int exp_q[$];
	logic [1:0] wr_q[$];
	logic [33:0] rd_q[$];
	logic [3:0] acc_q[$];

	always #5 clk = ~clk;
	assign pulse_vec = {aux_div_pulse, main_div_pulse, aux_ref_pulse, main_ref_pulse};

	signal_source #(.HALF(2)) ref_src (.clk(clk), .pin(ref_in));
	signal_source #(.HALF(3)) aux_src (.clk(clk), .pin(aux_in));
	signal_source #(.HALF(2)) rf_src (.clk(clk), .pin(rf_in));

	frac_n_synth_dividers dut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.ref_osc_input(ref_in), .aux_vco_input(aux_in), .main_rf_input(rf_in), .ref_buffer_enable,
		.aux_stage_enable, .main_stage_enable, .main_ref_pulse, .aux_ref_pulse, .main_div_pulse,
		.aux_div_pulse, .frac_acc_out, .comp_current_scale);

	// ****************************************
	// Bus, compare and measuring tasks
	// ****************************************
	task automatic chk_val(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	task automatic chk_gap(input string nm, input int e, input int g);
		n_tests++;
		if (g != e)
		begin
			bad_count++;
			$display("unexpected %s: expected %0d, seen %0d", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		wr_q.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end
		while (!bvalid);
		bready <= 1'h0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		rd_q.push_back(e);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'h0;
		end
		while (!rvalid);
		rready <= 1'h0;
		@(posedge clk);
	endtask

	// Expected pulse intervals and accumulator values are taken off their queues here.
	always @(posedge clk)
	begin
		cyc++;
		if (bvalid && bready)
			chk_val("write response", 34'(wr_q.pop_front()), 34'(bresp));
		if (rvalid && rready)
			chk_val("read data", rd_q.pop_front(), {rresp, rdata});
		if (acc_due > 0)
		begin
			acc_due--;
			if (acc_due == 0)
				chk_val("accumulator", 34'(acc_q.pop_front()), 34'(frac_acc_out));
		end
		if (pulse_vec[sel] === 1'h1)
		begin
			if (skip > 0)
				skip--;
			else
			begin
				if (exp_q.size() > 0)
					chk_gap("pulse interval", exp_q.pop_front(), cyc - last);
				if (acc_q.size() > 0)
					acc_due = 2;
			end
			last = cyc;
		end
	end

	task automatic wait_q();
		for (int i = 0; i < 30000 && exp_q.size() > 0; i++)
			@(posedge clk);
		repeat (3) @(posedge clk);
		chk_gap("unfinished intervals", 0, exp_q.size());
	endtask

	task automatic meas(input int s, input int sk, input int gap, input int k);
		sel = s;
		skip = sk;
		repeat (k) exp_q.push_back(gap);
		wait_q();
	endtask

	task automatic run_main(input logic hot, input int old, input logic [31:0] aux, input logic [31:0] a,
		input logic [31:0] b, input int n, input int k);
		int nf, fm, s, acc, ov;
		nf = int'(a[25:22]);
		fm = int'(b[13:10]) + 1;
		if (!hot)
			wr(OFF_REF, 32'h00000004, RESP_OKAY);
		wr(OFF_AUX, aux, RESP_OKAY);
		wr(OFF_MAIN_B, b, RESP_OKAY);
		wr(OFF_MAIN_A, a, RESP_OKAY);
		if (hot)
			meas(2, 1, old * 4, 2);
		wr(OFF_CTRL, 32'h00000001, RESP_OKAY);
		if (!hot)
			wr(OFF_REF, 32'h00010004, RESP_OKAY);
		sel = 2;
		skip = hot ? 2 : 1;
		ov = int'(nf >= fm);
		acc = ov ? nf - fm : nf;
		for (int i = 2; i <= k; i++)
		begin
			exp_q.push_back((n + ov) * 4);
			s = acc + nf;
			ov = int'(s >= fm);
			acc = ov ? s - fm : s;
			acc_q.push_back(acc[3:0]);
		end
		wait_q();
		chk_val("compensation scale", 34'(b[7:0]), 34'(comp_current_scale));
		rd(OFF_WORK, {RESP_OKAY, 32'(n) | (32'(b[9:8]) << WK_PR_LSB) | (32'(a[25:22]) << WK_NF_LSB)});
		wr(OFF_CTRL, 32'h00000000, RESP_OKAY);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		#850000;
		bad_count++;
		$display("unexpected run length: expected finish, seen timeout");
		wrap_up();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		void'($urandom(32'h1415986A));
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		rd(OFF_CTRL, {RESP_OKAY, RST_CTRL});
		rd(OFF_REF, {RESP_OKAY, RST_REF});
		rd(OFF_AUX, {RESP_OKAY, RST_AUX});
		rd(OFF_MAIN_A, {RESP_OKAY, RST_MAIN_A});
		rd(OFF_MAIN_B, {RESP_OKAY, RST_MAIN_B});
		rd(8'h1C, {RESP_SLVERR, 32'h0});
		wr(8'h1C, 32'hFFFFFFFF, RESP_SLVERR);
		wr(OFF_STATUS, 32'hFFFFFFFF, RESP_OKAY);
		rv = $urandom();
		wr(OFF_REF, rv, RESP_OKAY);
		rd(OFF_REF, {RESP_OKAY, rv & MASK_REF});
		rv = $urandom();
		wr(OFF_MAIN_A, rv, RESP_OKAY);
		rd(OFF_MAIN_A, {RESP_OKAY, rv & MASK_MAIN_A});
		$display("test registers done");
		for (int i = 0; i < 4; i++)
		begin
			wr(OFF_REF, {14'h0, 2'(i), 16'h0004}, RESP_OKAY);
			repeat (2) @(posedge clk);
			chk_val("enables", 34'({i[1] | i[0], i[1], i[0]}), 34'({ref_buffer_enable, aux_stage_enable,
				main_stage_enable}));
		end
		$display("test enables done");
		for (int r = 0; r < 4; r++)
		begin
			wr(OFF_REF, {14'h0, 2'h3, 2'(3 - r), 2'(r), 12'(4 + r)}, RESP_OKAY);
			meas(0, 2, (4 + r) * (1 << r) * 4, 2);
			meas(1, 2, (4 + r) * (1 << (3 - r)) * 4, 1);
		end
		$display("test reference divider done");
		for (int i = 0; i < 2; i++)
		begin
			wr(OFF_AUX, {18'h0, 10'(7 + 3 * i), 3'(7 - 5 * i), 1'h0}, RESP_OKAY);
			meas(3, 2, (8 * (7 + 3 * i - (7 - 5 * i)) + 9 * (7 - 5 * i)) * 6, 2);
		end
		$display("test aux divider done");
		run_main(1'h0, 0, 32'h00000071, 32'h008003E3, 32'h0000085A, 995, 5);
		run_main(1'h0, 0, 32'h00000070, 32'h00003002, 32'h000000A5, 451, 4);
		rd(OFF_STATUS, {RESP_OKAY, 32'h00000001 << ST_REFEN});
		run_main(1'h1, 451, 32'h00000070, 32'h0004200E, 32'h0000023C, 1298, 3);
		$display("test main divider done");
		wrap_up();
	end
endmodule

bind frac_n_synth_dividers frac_n_synth_dividers_assertions chk (.clk, .rst, .ref_buffer_enable, .aux_stage_enable,
	.main_stage_enable, .main_ref_pulse, .aux_ref_pulse, .main_div_pulse, .aux_div_pulse, .frac_acc_out,
	.comp_current_scale);
